/* src/tfs_pkg.sv */
// Shared constants and carrier types of the sync serial transmit FIFO and status block
package tfs_pkg;
  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_TXDATA = 8'h04;
  localparam logic [7:0] REG_CTRL   = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0c;
  localparam logic [7:0] REG_SYNC   = 8'h10;
  localparam logic [7:0] REG_RXDATA = 8'h14;
  // Control register fields
  localparam int CB_RXRST   = 0;
  localparam int CB_TXRST   = 1;
  localparam int CB_ONEBYTE = 2;
  localparam int CB_TXSYNC  = 3;
  localparam int CB_RIE     = 4;
  localparam int CB_TIE     = 5;
  localparam int CB_EIE     = 6;
  localparam int CB_EXTSYNC = 7;
  localparam int CB_WL      = 8;
  localparam int CB_ODD     = 10;
  localparam logic [10:0] CTRL_RST = 11'h003;
  localparam logic [7:0]  SYNC_RST = 8'h00;
  // Self-clearing command bits
  localparam int CMD_CLR_CS = 0;
  localparam int CMD_CLR_UF = 1;
  // Status bit positions
  localparam int ST_RDY  = 0;
  localparam int ST_ROOM = 1;
  localparam int ST_CD   = 2;
  localparam int ST_CS   = 3;
  localparam int ST_UF   = 4;
  localparam int ST_OVR  = 5;
  localparam int ST_PAR  = 6;
  localparam int ST_IRQ  = 7;
  // Bus enable strobe timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int E_PERIOD_NS   = 1000;
  localparam logic [7:0] E_DIV = 8'(E_PERIOD_NS / CLK_PERIOD_NS);
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } tfs_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } tfs_axi_rsp_t;

  typedef struct packed {
    logic       last_full;
    logic       mid_full;
    logic       overrun;
    logic       parity_bad;
    logic [7:0] data;
  } tfs_rx_t;

  typedef struct packed {
    logic       full;
    logic [7:0] data;
  } tfs_stage_t;
endpackage

/* src/tfs_fifo_stage.sv */
// One byte stage of the transmit FIFO with its own full flag
`timescale 1ns/100ps
`default_nettype none
module tfs_fifo_stage (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       load,
  input  wire logic [7:0] din,
  input  wire logic       take,
  output logic            full,
  output logic [7:0]      dout
);
  tfs_pkg::tfs_stage_t st_r;
  tfs_pkg::tfs_stage_t st_nxt;

  // Empty stage accepts a byte, full stage empties when drained
  always_comb begin
    st_nxt = st_r;
    if (clr) begin
      st_nxt.full = 1'b0;
    end else if (load && !st_r.full) begin
      st_nxt.full = 1'b1;
      st_nxt.data = din;
    end else if (take && st_r.full) begin
      st_nxt.full = 1'b0;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign full = st_r.full;
  assign dout = st_r.data;
endmodule
`default_nettype wire

/* src/tfs_top.sv */
// Transmit FIFO, serial transmitter and status register of the sync serial adapter
`timescale 1ns/100ps
`default_nettype none
// Function
// - Three byte stages, full stage moves to empty neighbour on each E pulse.
// - Unused upper data bits dropped; parity generated for FIFO data, and for sync code only with 8 data bits.
// - With no data, send sync code or an all ones fill.
// - Underflow output pulses one transmit clock high period, only in sync fill.
// - Status register is read only; reading it alone changes nothing.
// - Bit 0 shows stage 3 full, or stages 2 and 3 full.
// - Bit 1 shows stage 1 empty, or stages 1 and 2 empty.
// - Transmit soft reset inhibits bit 1, clears FIFO, release on next E.
// - High clear-to-send inhibits bit 1 except in external sync mode.
// - Bit 2 latches carrier rise; cleared by status then receive read.
// - Bit 3 latches clear-to-send rise; cleared by command or transmit soft reset.
// - Bit 4 sets on underflow in sync fill; cleared by command.
// - Bit 5 sets on receive overrun; cleared like bit 2.
// - Bit 6 flags parity of last stage; cleared by read or reset.
// - Bit 7 equals the interrupt output under the same enables.
// - Control one-byte bit selects single or double byte flag behaviour.
// - Control sync fill bit picks sync code or mark fill.
// - External sync bit set drops clear-to-send gating; reset clears it.
module tfs_top (
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET,
  input  wire tfs_pkg::tfs_axi_req_t AXI_REQ,
  output tfs_pkg::tfs_axi_rsp_t      AXI_RSP,
  input  wire tfs_pkg::tfs_rx_t      RX_IN,
  input  wire logic                 CARRIER_DETECT_N,
  input  wire logic                 CLEAR_SEND_N,
  input  wire logic                 TX_CLK,
  output logic                      TX_DATA,
  output logic                      UNDERFLOW,
  output logic                      IRQ_N,
  output logic                      RX_READ,
  output logic                      RX_SOFT_RESET
);
  typedef struct packed {
    tfs_pkg::tfs_axi_rsp_t rsp;
    logic        aw_ok;
    logic        w_ok;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [10:0] ctrl;
    logic [7:0]  sync;
    logic [7:0]  e_cnt;
    logic        e_stb;
    logic        cs_m;
    logic        cs_s;
    logic        cs_d;
    logic        cd_m;
    logic        cd_s;
    logic        cd_d;
    logic        tc_m;
    logic        tc_s;
    logic        tc_d;
    logic        cs_lat;
    logic        cd_lat;
    logic        ovr_lat;
    logic        tx_underflow_flag;
    logic        armed;
    logic        tx_clr;
    logic [8:0]  sh;
    logic [3:0]  bitcnt;
    logic        uf_o;
    logic        txd_o;
    logic        irq_n;
    logic        rx_read;
  } tfs_state_t;

  tfs_state_t st_r;
  tfs_state_t st_nxt;

  logic       tx_wr;
  logic [7:0] tx_byte;
  logic       mv12;
  logic       mv23;
  logic       take3;
  logic [2:0] full;
  logic [7:0] d1;
  logic [7:0] d2;
  logic [7:0] d3;
  logic [7:0] status;
  logic [7:0] mask;
  logic [3:0] dbits;
  logic       room;
  logic       rdy;
  logic       par_bad;
  logic       irq;

  // Data bit mask and count for the selected word length
  always_comb begin
    unique case (st_r.ctrl[tfs_pkg::CB_WL +: 2])
      2'h0: begin
        mask  = 8'h3f;
        dbits = 4'h6;
      end
      2'h1: begin
        mask  = 8'h7f;
        dbits = 4'h7;
      end
      default: begin
        mask  = 8'hff;
        dbits = 4'h8;
      end
    endcase
  end

  // Character with generated parity above the data bits
  function automatic logic [8:0] with_par(input logic [7:0] d,
                                          input logic [7:0] m,
                                          input logic [3:0] n,
                                          input logic       odd);
    logic [8:0] c;
    c = {1'b0, d & m};
    if ((^(d & m)) ^ odd) begin
      c = c | (9'h001 << n);
    end
    return c;
  endfunction

  // Three stage transmit FIFO
  assign mv12  = st_r.e_stb && full[0] && !full[1];
  assign mv23  = st_r.e_stb && full[1] && !full[2];
  assign tx_byte = st_r.wdata[7:0] & mask;

  tfs_fifo_stage u_s1 (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .clr  (st_r.tx_clr),
    .load (tx_wr),
    .din  (tx_byte),
    .take (mv12),
    .full (full[0]),
    .dout (d1)
  );
  tfs_fifo_stage u_s2 (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .clr  (st_r.tx_clr),
    .load (mv12),
    .din  (d1),
    .take (mv23),
    .full (full[1]),
    .dout (d2)
  );
  tfs_fifo_stage u_s3 (
    .clk  (CLK_SYS),
    .rst  (RESET),
    .clr  (st_r.tx_clr),
    .load (mv23),
    .din  (d2),
    .take (take3),
    .full (full[2]),
    .dout (d3)
  );

  // Live status and interrupt request
  always_comb begin
    if (st_r.ctrl[tfs_pkg::CB_ONEBYTE]) begin
      rdy  = RX_IN.last_full;
      room = !full[0];
    end else begin
      rdy  = RX_IN.last_full && RX_IN.mid_full;
      room = !full[0] && !full[1];
    end
    rdy  = rdy && !st_r.ctrl[tfs_pkg::CB_RXRST];
    room = room && !st_r.ctrl[tfs_pkg::CB_TXRST];
    if (st_r.cs_s && !st_r.ctrl[tfs_pkg::CB_EXTSYNC]) begin
      room = 1'b0;
    end
    par_bad = RX_IN.parity_bad && RX_IN.last_full
              && !st_r.ctrl[tfs_pkg::CB_RXRST];
    irq = (rdy && st_r.ctrl[tfs_pkg::CB_RIE])
          || (room && st_r.ctrl[tfs_pkg::CB_TIE])
          || (st_r.ctrl[tfs_pkg::CB_EIE] && (st_r.ovr_lat || st_r.cd_lat
              || par_bad || st_r.cs_lat || st_r.tx_underflow_flag));
    status                  = '0;
    status[tfs_pkg::ST_RDY]  = rdy;
    status[tfs_pkg::ST_ROOM] = room;
    status[tfs_pkg::ST_CD]   = st_r.cd_lat || st_r.cd_s;
    status[tfs_pkg::ST_CS]   = st_r.cs_lat || st_r.cs_s;
    status[tfs_pkg::ST_UF]   = st_r.tx_underflow_flag;
    status[tfs_pkg::ST_OVR]  = st_r.ovr_lat;
    status[tfs_pkg::ST_PAR]  = par_bad;
    status[tfs_pkg::ST_IRQ]  = !st_r.irq_n;
  end

  // Next state of bus slave, latches and transmitter
  always_comb begin
    logic       wr;
    logic       rd;
    logic       cd_clr;
    logic       tc_rise;
    logic [8:0] ch;
    wr      = st_r.aw_ok && st_r.w_ok && !st_r.rsp.bvalid;
    rd      = st_r.rsp.arready && AXI_REQ.arvalid;
    cd_clr  = 1'b0;
    tc_rise = st_r.tc_s && !st_r.tc_d;
    ch      = '0;
    st_nxt  = st_r;
    tx_wr   = 1'b0;
    take3   = 1'b0;
    st_nxt.rx_read = 1'b0;
    // Pin synchronisers; a high pin level is the event and the inhibit
    st_nxt.cs_m = CLEAR_SEND_N;
    st_nxt.cs_s = st_r.cs_m;
    st_nxt.cs_d = st_r.cs_s;
    st_nxt.cd_m = CARRIER_DETECT_N;
    st_nxt.cd_s = st_r.cd_m;
    st_nxt.cd_d = st_r.cd_s;
    st_nxt.tc_m = TX_CLK;
    st_nxt.tc_s = st_r.tc_m;
    st_nxt.tc_d = st_r.tc_s;
    // E strobe divider
    st_nxt.e_stb = 1'b0;
    if (st_r.e_cnt == tfs_pkg::E_DIV - 8'h01) begin
      st_nxt.e_cnt = '0;
      st_nxt.e_stb = 1'b1;
    end else begin
      st_nxt.e_cnt = st_r.e_cnt + 8'h01;
    end
    // FIFO held clear until the next E pulse after soft reset
    if (st_r.e_stb) begin
      st_nxt.tx_clr = 1'b0;
    end
    // Address and data channels taken in either order
    if (st_r.rsp.awready && AXI_REQ.awvalid) begin
      st_nxt.aw_ok  = 1'b1;
      st_nxt.awaddr = AXI_REQ.awaddr;
    end
    if (st_r.rsp.wready && AXI_REQ.wvalid) begin
      st_nxt.w_ok  = 1'b1;
      st_nxt.wdata = AXI_REQ.wdata;
      st_nxt.wstrb = AXI_REQ.wstrb;
    end
    if (st_r.rsp.bvalid && AXI_REQ.bready) begin
      st_nxt.rsp.bvalid = 1'b0;
    end
    if (st_r.rsp.rvalid && AXI_REQ.rready) begin
      st_nxt.rsp.rvalid = 1'b0;
    end
    // Register write
    if (wr) begin
      st_nxt.aw_ok      = 1'b0;
      st_nxt.w_ok       = 1'b0;
      st_nxt.rsp.bvalid = 1'b1;
      st_nxt.rsp.bresp  = tfs_pkg::RESP_OKAY;
      unique case (st_r.awaddr)
        tfs_pkg::REG_STATUS: begin
        end
        tfs_pkg::REG_TXDATA: begin
          tx_wr = st_r.wstrb[0];
        end
        tfs_pkg::REG_CTRL: begin
          if (st_r.wstrb[0]) begin
            st_nxt.ctrl[7:0] = st_r.wdata[7:0];
            if (st_r.wdata[tfs_pkg::CB_TXRST]) begin
              st_nxt.tx_clr = 1'b1;
              st_nxt.cs_lat = 1'b0;
              st_nxt.tx_underflow_flag    = 1'b0;
            end
            if (st_r.wdata[tfs_pkg::CB_RXRST]) begin
              cd_clr = 1'b1;
            end
          end
          if (st_r.wstrb[1]) begin
            st_nxt.ctrl[10:8] = st_r.wdata[10:8];
          end
        end
        tfs_pkg::REG_CMD: begin
          if (st_r.wstrb[0] && st_r.wdata[tfs_pkg::CMD_CLR_CS]) begin
            st_nxt.cs_lat = 1'b0;
          end
          if (st_r.wstrb[0] && st_r.wdata[tfs_pkg::CMD_CLR_UF]) begin
            st_nxt.tx_underflow_flag = 1'b0;
          end
        end
        tfs_pkg::REG_SYNC: begin
          if (st_r.wstrb[0]) begin
            st_nxt.sync = st_r.wdata[7:0];
          end
        end
        default: begin
          st_nxt.rsp.bresp = tfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Register read; a status read arms the latch clear, the receive data read pops and clears
    if (rd) begin
      st_nxt.rsp.rvalid = 1'b1;
      st_nxt.rsp.rresp  = tfs_pkg::RESP_OKAY;
      st_nxt.rsp.rdata  = '0;
      unique case (AXI_REQ.araddr)
        tfs_pkg::REG_STATUS: begin
          st_nxt.rsp.rdata[7:0] = status;
          st_nxt.armed          = 1'b1;
        end
        tfs_pkg::REG_CTRL: begin
          st_nxt.rsp.rdata[10:0] = st_r.ctrl;
        end
        tfs_pkg::REG_SYNC: begin
          st_nxt.rsp.rdata[7:0] = st_r.sync;
        end
        tfs_pkg::REG_RXDATA: begin
          st_nxt.rsp.rdata[7:0] = RX_IN.data & mask;
          st_nxt.rx_read        = 1'b1;
          st_nxt.armed          = 1'b0;
          cd_clr                = cd_clr || st_r.armed;
        end
        default: begin
          st_nxt.rsp.rresp = tfs_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (st_r.ctrl[tfs_pkg::CB_RXRST]) begin
      cd_clr = 1'b1;
    end
    if (cd_clr) begin
      st_nxt.cd_lat  = 1'b0;
      st_nxt.ovr_lat = 1'b0;
    end
    // Latched events; a set wins over a clear in the same cycle
    if (st_r.cd_s && !st_r.cd_d) begin
      st_nxt.cd_lat = 1'b1;
    end
    if (st_r.cs_s && !st_r.cs_d) begin
      st_nxt.cs_lat = 1'b1;
    end
    if (RX_IN.overrun && !st_r.ctrl[tfs_pkg::CB_RXRST]) begin
      st_nxt.ovr_lat = 1'b1;
    end
    // Underflow pulse ends on the falling transmit clock edge
    if (!st_r.tc_s && st_r.tc_d) begin
      st_nxt.uf_o = 1'b0;
    end
    // Serial transmitter, one bit per rising transmit clock edge
    if (tc_rise) begin
      if (st_r.bitcnt != 4'h0) begin
        st_nxt.txd_o  = st_r.sh[0];
        st_nxt.sh     = st_r.sh >> 1;
        st_nxt.bitcnt = st_r.bitcnt - 4'h1;
      end else begin
        if (full[2] && !st_r.ctrl[tfs_pkg::CB_TXRST]) begin
          take3 = 1'b1;
          ch = with_par(d3, mask, dbits, st_r.ctrl[tfs_pkg::CB_ODD]);
        end else if (st_r.ctrl[tfs_pkg::CB_TXSYNC]) begin
          ch = {1'b1, st_r.sync & mask} | ~({1'b1, mask});
          if (dbits == 4'h8) begin
            ch = with_par(st_r.sync, mask, dbits,
                          st_r.ctrl[tfs_pkg::CB_ODD]);
          end
          if (!st_r.ctrl[tfs_pkg::CB_TXRST]) begin
            st_nxt.tx_underflow_flag  = 1'b1;
            st_nxt.uf_o = 1'b1;
          end
        end else begin
          ch = 9'h1ff;
        end
        st_nxt.txd_o  = ch[0];
        st_nxt.sh     = ch >> 1;
        st_nxt.bitcnt = dbits;
      end
    end
    // Interrupt output and status bit 7 share one flop
    st_nxt.irq_n = !irq;
    // Ready signals offered for the next cycle
    st_nxt.rsp.awready = !st_nxt.aw_ok && !st_nxt.rsp.bvalid;
    st_nxt.rsp.wready  = !st_nxt.w_ok && !st_nxt.rsp.bvalid;
    st_nxt.rsp.arready = !st_nxt.rsp.rvalid;
  end

  // State register
  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      st_r        <= '0;
      st_r.ctrl   <= tfs_pkg::CTRL_RST;
      st_r.sync   <= tfs_pkg::SYNC_RST;
      st_r.tx_clr <= 1'b1;
      st_r.irq_n  <= 1'b1;
      st_r.txd_o  <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign AXI_RSP       = st_r.rsp;
  assign TX_DATA       = st_r.txd_o;
  assign UNDERFLOW     = st_r.uf_o;
  assign IRQ_N         = st_r.irq_n;
  assign RX_READ       = st_r.rx_read;
  assign RX_SOFT_RESET = st_r.ctrl[tfs_pkg::CB_RXRST];

  // Checks
  a_room_txrst: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_r.ctrl[tfs_pkg::CB_TXRST] |-> !status[tfs_pkg::ST_ROOM])
    else $error("room flag shown during transmit soft reset");
  a_room_clear_send: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_r.cs_s && !st_r.ctrl[tfs_pkg::CB_EXTSYNC] |-> !status[tfs_pkg::ST_ROOM])
    else $error("room flag not inhibited by clear-to-send");
  a_irq_bit_match: assert property (@(posedge CLK_SYS) disable iff (RESET)
    status[tfs_pkg::ST_IRQ] == !IRQ_N && ($past(irq) == !IRQ_N))
    else $error("status bit 7 differs from interrupt output");
  a_uf_only_sync: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(UNDERFLOW) |-> $past(st_r.ctrl[tfs_pkg::CB_TXSYNC]) && st_r.tx_underflow_flag)
    else $error("underflow pulse without sync fill");
  a_cs_latch: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_r.cs_s && !st_r.cs_d |=> st_r.cs_lat [*2])
    else $error("clear-to-send rise not latched");
  a_cd_latch: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_r.cd_s && !st_r.cd_d |=> status[tfs_pkg::ST_CD])
    else $error("carrier rise not latched");
  a_ovr_set: assert property (@(posedge CLK_SYS) disable iff (RESET)
    RX_IN.overrun && !st_r.ctrl[tfs_pkg::CB_RXRST] |=> st_r.ovr_lat)
    else $error("overrun not latched");
  a_clr_release: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_r.tx_clr |-> ##[0:205] !st_r.tx_clr ##1 (full == 3'h0 || tx_wr || $past(tx_wr)))
    else $error("FIFO clear not released by E pulse");
  a_stage_shift: assert property (@(posedge CLK_SYS) disable iff (RESET)
    $rose(full[1]) |-> $past(st_r.e_stb) && $past(full[0]))
    else $error("stage 2 filled off the E pulse");
  a_rdy_onebyte: assert property (@(posedge CLK_SYS) disable iff (RESET)
    st_r.ctrl[tfs_pkg::CB_ONEBYTE] && !st_r.ctrl[tfs_pkg::CB_RXRST]
    |-> status[tfs_pkg::ST_RDY] == RX_IN.last_full)
    else $error("receive ready flag wrong in one-byte mode");
endmodule
`default_nettype wire

/* verif/tfs_line_model.sv */
// Serial line partner: makes the bit clock in frames and collects bits
`timescale 1ns/100ps
`default_nettype none
module tfs_line_model #(
  parameter int HALF_NS = 100
) (
  input  wire logic        tx_data,
  input  wire logic        underflow,
  input  wire logic [15:0] goal,
  output logic             tx_clk,
  output logic [15:0]      bit_cnt,
  output logic [8:0]       frame,
  output logic [7:0]       uf_cnt,
  output logic [15:0]      uf_w
);
  realtime t_up;

  // Idle values; the bit clock stands low between frames
  initial begin
    tx_clk = 1'b0;
    bit_cnt = '0;
    frame = '0;
    uf_cnt = '0;
    uf_w = '0;
    t_up = 0.0;
  end

  // One bit per period until the wanted count, sampled at the falling edge
  // The frame starts 1 ns late so no bit clock edge meets a system clock edge
  always begin
    wait (bit_cnt < goal);
    #1;
    while (bit_cnt < goal) begin
      #(HALF_NS) tx_clk = 1'b1;
      #(HALF_NS) tx_clk = 1'b0;
      frame = {tx_data, frame[8:1]};
      bit_cnt = bit_cnt + 16'h0001;
    end
  end

  // Width of each fill pulse; the reset edge at time zero is not a pulse
  always @(posedge underflow) t_up = $realtime;
  always @(negedge underflow) begin
    if (t_up > 0.0) begin
      uf_cnt = uf_cnt + 8'h01;
      uf_w = 16'($rtoi($realtime - t_up));
    end
  end
endmodule
`default_nettype wire

/* verif/tb_tfs_top.sv */
// Self-checking testbench of the transmit FIFO and status block
`timescale 1ns/100ps
`default_nettype none
module tb_tfs_top;
  logic                  clk_sys = 1'b0;
  logic                  reset = 1'b1;
  tfs_pkg::tfs_axi_req_t req = '0;
  tfs_pkg::tfs_axi_rsp_t rsp;
  tfs_pkg::tfs_rx_t      rx = '0;
  logic                  carrier_n = 1'b0;
  logic                  cts_n = 1'b0;
  logic                  tx_clk;
  logic                  tx_data;
  logic                  uf;
  logic                  irq_n;
  logic                  rx_srst;
  logic                  rx_rd;
  int                    rx_reads = 0;
  logic [15:0]           goal = '0;
  logic [15:0]           bit_cnt;
  logic [8:0]            frame;
  logic [7:0]            uf_cnt;
  logic [15:0]           uf_w;
  logic [31:0]           rdat;
  logic [1:0]            resp;
  int                    failures = 0;
  int                    compares = 0;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  // Counts receive pop pulses, sampled away from the launching edge
  always @(negedge clk_sys) begin
    if (rx_rd) begin
      rx_reads++;
    end
  end

  tfs_top dut_u (
    .CLK_SYS          (clk_sys),
    .RESET            (reset),
    .AXI_REQ          (req),
    .AXI_RSP          (rsp),
    .RX_IN            (rx),
    .CARRIER_DETECT_N (carrier_n),
    .CLEAR_SEND_N     (cts_n),
    .TX_CLK           (tx_clk),
    .TX_DATA          (tx_data),
    .UNDERFLOW        (uf),
    .IRQ_N            (irq_n),
    .RX_READ          (rx_rd),
    .RX_SOFT_RESET    (rx_srst)
  );

  tfs_line_model line_u (
    .tx_data   (tx_data),
    .underflow (uf),
    .goal      (goal),
    .tx_clk    (tx_clk),
    .bit_cnt   (bit_cnt),
    .frame     (frame),
    .uf_cnt    (uf_cnt),
    .uf_w      (uf_w)
  );

  task automatic tally_and_finish;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    failures++;
    tally_and_finish();
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge clk_sys);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk_sys);
      ta = req.awvalid & rsp.awready;
      tw = req.wvalid & rsp.wready;
      tb = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk_sys);
      if (ta) req.awvalid <= 1'b0;
      if (tw) req.wvalid <= 1'b0;
      if (tb) begin
        req.bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // Read: address held until taken, rready held until data is seen
  task automatic rd(input logic [7:0] a);
    logic ta, tv;
    @(posedge clk_sys);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(negedge clk_sys);
      ta = req.arvalid & rsp.arready;
      tv = rsp.rvalid;
      rdat = rsp.rdata;
      resp = rsp.rresp;
      @(posedge clk_sys);
      if (ta) req.arvalid <= 1'b0;
      if (tv) begin
        req.rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic st(input logic [7:0] e);
    rd(tfs_pkg::REG_STATUS);
    chk(rdat, {24'h0, e});
  endtask

  // Lets the line partner clock out k bits
  task automatic run_bits(input int k);
    goal <= bit_cnt + 16'(k);
    idle(2);
    for (int n = 0; n < 4000 && bit_cnt != goal; n++) idle(1);
    if (bit_cnt != goal) hang();
  endtask

  task automatic t_reset_bus;
    rd(tfs_pkg::REG_CTRL);
    chk(rdat, 32'h003);
    st(8'h00);
    chk(irq_n, 1);
    chk(rx_srst, 1);
    rd(8'h3c);
    chk(resp, tfs_pkg::RESP_SLVERR);
    wr(tfs_pkg::REG_STATUS, 32'hff);
    chk(resp, tfs_pkg::RESP_OKAY);
    st(8'h00);
  endtask

  // Three stages fill, drain one and show room in one-byte mode, none in double-byte mode
  task automatic t_fifo;
    wr(tfs_pkg::REG_CTRL, 32'h204);
    idle(400);
    st(8'h02);
    wr(tfs_pkg::REG_TXDATA, 32'ha5);
    st(8'h00);
    idle(210);
    wr(tfs_pkg::REG_TXDATA, 32'h3c);
    idle(410);
    wr(tfs_pkg::REG_TXDATA, 32'h0f);
    idle(600);
    st(8'h00);
    run_bits(9);
    chk(frame, 9'h0a5);
    idle(500);
    st(8'h02);
    wr(tfs_pkg::REG_CTRL, 32'h200);
    st(8'h00);
  endtask

  // Sync fill with its pulse and flag, then mark fill without either
  task automatic t_underflow;
    wr(tfs_pkg::REG_SYNC, 32'h7e);
    wr(tfs_pkg::REG_CTRL, 32'h248);
    run_bits(27);
    chk(frame, 9'h07e);
    chk(uf_cnt, 1);
    chk(uf_w >= 80 && uf_w <= 120, 1);
    st(8'h92);
    chk(irq_n, 0);
    wr(tfs_pkg::REG_CMD, 32'h2);
    st(8'h02);
    chk(irq_n, 1);
    wr(tfs_pkg::REG_CTRL, 32'h200);
    run_bits(9);
    chk(frame, 9'h1ff);
    chk(uf_cnt, 1);
    st(8'h02);
  endtask

  // Clear-to-send gating, latch, command clear and external sync
  task automatic t_handshake;
    cts_n <= 1'b1;
    idle(8);
    st(8'h08);
    cts_n <= 1'b0;
    idle(8);
    st(8'h0a);
    wr(tfs_pkg::REG_CMD, 32'h1);
    st(8'h02);
    wr(tfs_pkg::REG_CTRL, 32'h280);
    cts_n <= 1'b1;
    idle(8);
    st(8'h0a);
    wr(tfs_pkg::REG_CMD, 32'h1);
    st(8'h0a);
    cts_n <= 1'b0;
    idle(8);
    st(8'h02);
  endtask

  // Receive side flags, carrier and overrun latches, interrupt bit
  task automatic t_receive;
    wr(tfs_pkg::REG_CTRL, 32'h244);
    rx.last_full <= 1'b1;
    rx.data <= 8'h5a;
    idle(4);
    st(8'h03);
    carrier_n <= 1'b1;
    idle(8);
    carrier_n <= 1'b0;
    rx.overrun <= 1'b1;
    idle(1);
    rx.overrun <= 1'b0;
    idle(8);
    st(8'ha7);
    chk(irq_n, 0);
    st(8'ha7);
    rd(tfs_pkg::REG_RXDATA);
    chk(rdat, 32'h5a);
    chk(rx_reads, 32'h1);
    st(8'h03);
    rx.parity_bad <= 1'b1;
    idle(4);
    st(8'hc3);
    carrier_n <= 1'b1;
    idle(8);
    st(8'hc7);
    wr(tfs_pkg::REG_CTRL, 32'h240);
    st(8'hc6);
    rx.mid_full <= 1'b1;
    idle(4);
    st(8'hc7);
    rx <= '0;
    carrier_n <= 1'b0;
  endtask

  // Preload of three bytes under transmit soft reset
  task automatic t_preload;
    wr(tfs_pkg::REG_CTRL, 32'h203);
    idle(210);
    st(8'h00);
    chk(rx_srst, 1);
    wr(tfs_pkg::REG_TXDATA, 32'h11);
    idle(210);
    wr(tfs_pkg::REG_TXDATA, 32'he2);
    idle(410);
    wr(tfs_pkg::REG_TXDATA, 32'h33);
    idle(600);
    st(8'h00);
    wr(tfs_pkg::REG_CTRL, 32'h205);
    run_bits(9);
    chk(frame, 9'h011);
    idle(500);
    st(8'h02);
    // Six data bits with odd parity: upper bits of the stored byte dropped
    wr(tfs_pkg::REG_CTRL, 32'h405);
    run_bits(7);
    chk(frame, 9'h188);
  endtask

  // Reset for 8 cycles, then the scenarios in turn
  initial begin
    idle(8);
    reset <= 1'b0;
    idle(1);
    t_reset_bus();
    t_fifo();
    t_underflow();
    t_handshake();
    t_receive();
    t_preload();
    tally_and_finish();
  end
endmodule
`default_nettype wire
